// File: hdl/chdiag_consts.svh
// Offsets, diagnosis byte fields and timing counts of the channel diag block
`ifndef CHDIAG_CONSTS_SVH
`define CHDIAG_CONSTS_SVH
`define CLK_PERIOD_NS 5
`define CHECK_PERIOD_NS 100000
`define DIAG_HEAD 8'h80
`define DIAG_IO_INPUT 2'h1
`define DIAG_DTYPE 3'h1
`define FCODE_RECOVER 5'h00
`define FCODE_ACQ 5'h12
`define COMM_OK 8'h01
`define COMM_BAD 8'h00
`define OFS_CFG 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONFIRM 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
`define IRQ_ACQ 0
`define IRQ_RECOVER 1
`define IRQ_PSAFE 2
`define IRQ_W 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: hdl/chdiag_pkg.sv
// Types shared by the channel diagnosis and safe state block
package chdiag_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HEAD = 2'b01,
		ST_CHAN = 2'b10,
		ST_TYPE = 2'b11
	} diag_state_t;
	typedef logic [7:0] chan_vec_t;
endpackage

// File: hdl/channel_diag_safe_state.sv
// Channel diagnosis records, safe state and fault-safe status of an 8-ch DI
// Function
// - each diagnosis record starts with header byte 0x80 (128)
// - second byte is 01 input marker plus channel index, 64..71
// - third byte for fault recovery is type 001, code 0: value 32
// - third byte for acquisition fault carries code 18: value 50
// - fault check at power-on, then periodic; set quality, substitute
// - communication or module failure drives channels to safe state
// - fault-safe fault sets error status, safe state, safety values
// - fault-safe fault auto-confirmed once gone; normal output resumes
// - confirm word reads 0 while fault pending, 1 otherwise
// - communication status byte is 1 when healthy, other value abnormal
// - hold mode keeps last value, preset mode takes safety value
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "chdiag_consts.svh"

module channel_diag_safe_state #(
	parameter int CHECK_CYCLES = `CHECK_PERIOD_NS / `CLK_PERIOD_NS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire chdiag_pkg::chan_vec_t chan_in,
	input wire chdiag_pkg::chan_vec_t acq_fault,
	input wire logic comm_fail,
	input wire logic module_fail,
	input wire logic psafe_fault,
	output chdiag_pkg::chan_vec_t chan_value,
	output chdiag_pkg::chan_vec_t chan_quality,
	output logic safety_error,
	output logic [15:0] slave_confirm_state,
	output logic [7:0] slave_comm_state,
	output logic diag_valid,
	output logic [7:0] diag_data,
	input wire logic diag_ready,
	output logic irq
);
	import chdiag_pkg::*;

	function automatic logic [2:0] lowest_set(input chan_vec_t v);
		lowest_set = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				lowest_set = 3'(i);
			end
		end
	endfunction

	// ****************************************************************
	// Register bus
	// ****************************************************************
	chan_vec_t preset_q, safe_val_q;
	logic [`IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
	logic wr_go, rd_go, wr_hit;
	logic [31:0] rd_mux;
	logic rd_hit;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign wr_hit = s_axi_awaddr == `OFS_CFG ||
		s_axi_awaddr == `OFS_IRQ_STAT || s_axi_awaddr == `OFS_IRQ_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Mode bits in lane 0, safety values in lane 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			preset_q <= 8'h00;
			safe_val_q <= 8'h00;
			irq_mask_q <= '0;
		end else if (wr_go) begin
			if (s_axi_awaddr == `OFS_CFG && s_axi_wstrb[0]) begin
				preset_q <= s_axi_wdata[7:0];
			end
			if (s_axi_awaddr == `OFS_CFG && s_axi_wstrb[1]) begin
				safe_val_q <= s_axi_wdata[15:8];
			end
			if (s_axi_awaddr == `OFS_IRQ_MASK && s_axi_wstrb[0]) begin
				irq_mask_q <= s_axi_wdata[`IRQ_W-1:0];
			end
		end
	end

	// New events win over a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else if (wr_go && s_axi_awaddr == `OFS_IRQ_STAT &&
			s_axi_wstrb[0]) begin
			irq_stat_q <= (irq_stat_q & ~s_axi_wdata[`IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
		`OFS_CFG: rd_mux = {16'h0000, safe_val_q, preset_q};
		`OFS_STATUS: rd_mux = {8'h00, slave_comm_state, 7'h00,
			safety_error, chan_quality};
		`OFS_CONFIRM: rd_mux = {16'h0000, slave_confirm_state};
		`OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
		`OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
		default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Acquisition fault check
	// ****************************************************************
	logic [31:0] chk_cnt_q;
	logic first_chk_q, check_now;
	chan_vec_t fault_q;

	// One check right after reset, then one per period
	assign check_now = first_chk_q || chk_cnt_q == 32'(CHECK_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_chk_q <= 1'b1;
			chk_cnt_q <= 32'h0000_0000;
			fault_q <= 8'h00;
		end else begin
			first_chk_q <= 1'b0;
			chk_cnt_q <= check_now ? 32'h0000_0000 : chk_cnt_q + 32'h1;
			if (check_now) begin
				fault_q <= acq_fault;
			end
		end
	end

	// ****************************************************************
	// Channel values and safe state
	// ****************************************************************
	logic safe_all;
	chan_vec_t held, val_d, hold_m;

	assign safe_all = comm_fail || module_fail || psafe_fault;
	assign held = (preset_q & safe_val_q) | (~preset_q & chan_value);
	assign hold_m = fault_q & ~preset_q & ~{8{safe_all}};
	assign val_d = safe_all ? safe_val_q :
		(fault_q & held) | (~fault_q & chan_in);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_value <= 8'h00;
			chan_quality <= 8'hff;
			safety_error <= 1'b0;
			slave_confirm_state <= 16'h0000;
			slave_comm_state <= `COMM_BAD;
		end else begin
			chan_value <= val_d;
			chan_quality <= fault_q | {8{safe_all}};
			// Error follows the fault; clearing is the automatic confirm
			safety_error <= psafe_fault;
			slave_confirm_state <= {15'h0000, !psafe_fault};
			slave_comm_state <= comm_fail ? `COMM_BAD : `COMM_OK;
		end
	end

	// ****************************************************************
	// Diagnosis record emitter
	// ****************************************************************
	diag_state_t state_q;
	chan_vec_t rep_q;
	logic [2:0] rec_ch_q;
	logic rec_fault_q, take, psafe_q;

	assign diag_valid = state_q != ST_IDLE;
	assign take = diag_valid && diag_ready;

	// A record is never interrupted, so bytes cannot interleave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			diag_data <= 8'h00;
			rep_q <= 8'h00;
			rec_ch_q <= 3'h0;
			rec_fault_q <= 1'b0;
		end else begin
			unique case (state_q)
			ST_IDLE: if (fault_q != rep_q) begin
				rec_ch_q <= lowest_set(fault_q ^ rep_q);
				rec_fault_q <= fault_q[lowest_set(fault_q ^ rep_q)];
				diag_data <= `DIAG_HEAD;
				state_q <= ST_HEAD;
			end
			ST_HEAD: if (take) begin
				diag_data <= {`DIAG_IO_INPUT, 3'h0, rec_ch_q};
				state_q <= ST_CHAN;
			end
			ST_CHAN: if (take) begin
				diag_data <= {`DIAG_DTYPE, rec_fault_q ?
					`FCODE_ACQ : `FCODE_RECOVER};
				state_q <= ST_TYPE;
			end
			ST_TYPE: if (take) begin
				rep_q[rec_ch_q] <= rec_fault_q;
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psafe_q <= 1'b0;
		end else begin
			psafe_q <= psafe_fault;
		end
	end

	// One process drives every event bit, so the vector has a single driver
	always_comb begin
		irq_ev = '0;
		irq_ev[`IRQ_ACQ] = state_q == ST_TYPE && take && rec_fault_q;
		irq_ev[`IRQ_RECOVER] = state_q == ST_TYPE && take && !rec_fault_q;
		irq_ev[`IRQ_PSAFE] = psafe_fault && !psafe_q;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_head_byte: assert property (
		state_q == ST_HEAD |-> diag_data == 8'h80)
		else $error("record header is not 0x80");
	a_chan_byte: assert property (
		state_q == ST_CHAN |-> diag_data >= 8'd64 && diag_data <= 8'd71
		&& diag_data[2:0] == rec_ch_q)
		else $error("channel byte out of 64..71");
	a_recover_byte: assert property (
		state_q == ST_TYPE && !rec_fault_q |-> diag_data == 8'd32)
		else $error("recovery byte is not 32");
	a_acq_byte: assert property (
		state_q == ST_TYPE && rec_fault_q |-> diag_data == 8'd50)
		else $error("acquisition byte is not 50");
	a_quality_flag: assert property (
		(|fault_q) |=> (chan_quality & $past(fault_q)) == $past(fault_q))
		else $error("faulty channel quality not set");
	a_safe_failure: assert property (
		comm_fail || module_fail |=> chan_value == $past(safe_val_q)
		&& chan_quality == 8'hff)
		else $error("failure did not force safe state");
	a_psafe_error: assert property (
		psafe_fault |=> safety_error && chan_value == $past(safe_val_q))
		else $error("fault-safe fault not handled");
	a_auto_confirm: assert property (
		$fell(psafe_fault) && !comm_fail && !module_fail && fault_q == 8'h00
		|=> !safety_error && chan_value == $past(chan_in))
		else $error("fault not confirmed automatically");
	a_confirm_word: assert property (
		aresetn |=> slave_confirm_state ==
		($past(psafe_fault) ? 16'h0000 : 16'h0001))
		else $error("confirm word wrong");
	a_comm_byte: assert property (
		aresetn |=> (slave_comm_state == 8'h01) == !$past(comm_fail))
		else $error("communication byte wrong");
	a_hold_mode: assert property (
		(|hold_m) |=> (chan_value & $past(hold_m)) ==
		($past(chan_value) & $past(hold_m)))
		else $error("hold mode channel changed");
	a_record_order: assert property (
		state_q == ST_HEAD && take |=> state_q == ST_CHAN
		##[0:1000] state_q == ST_TYPE)
		else $error("record bytes out of order");

	c_fault_record: cover property (state_q == ST_TYPE && take && rec_fault_q);
	c_recover_record: cover property (irq_ev[`IRQ_RECOVER]);
	c_psafe_recover: cover property (psafe_fault ##[1:20] !psafe_fault);
	c_hold_used: cover property (|hold_m);

endmodule // channel_diag_safe_state

// File: testbench/diag_sink.sv
// Diagnosis byte sink standing in for the bus master
`timescale 1ns/1ps
module diag_sink (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic diag_valid,
	input wire logic [7:0] diag_data,
	output logic diag_ready,
	output logic got,
	output logic [7:0] got_data
);
	// Random stalls so that bytes must stand across several edges
	always_ff @(posedge aclk) begin
		diag_ready <= aresetn & 1'($urandom_range(1));
		got <= aresetn & diag_valid & diag_ready;
		got_data <= diag_data;
	end
endmodule // diag_sink

// File: testbench/test_channel_diag_safe_state.sv
// Self-checking bench for the channel diagnosis and safe state block
`timescale 1ns/1ps
`include "chdiag_consts.svh"
module test_channel_diag_safe_state;
	import chdiag_pkg::*;
	logic aclk, aresetn, awv, wv, bready, arv, rready;
	logic comm_fail, module_fail, psafe_fault, diag_ready, got;
	logic [7:0] awaddr, araddr, got_data, r;
	logic [31:0] wdata;
	chan_vec_t chan_in, acq_fault;
	wire logic awready, wready, bvalid, arready, rvalid, safety_error;
	wire logic diag_valid, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire chan_vec_t chan_value, chan_quality;
	wire logic [15:0] confirm;
	wire logic [7:0] comm, diag_data;
	wire logic [3:0] rdy = {rvalid, arready, bvalid, awready & wready};
	int errors = 0;
	int compares = 0;
	logic [7:0] q[$];

	channel_diag_safe_state #(.CHECK_CYCLES(8)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .chan_in(chan_in), .acq_fault(acq_fault),
		.comm_fail(comm_fail), .module_fail(module_fail),
		.psafe_fault(psafe_fault), .chan_value(chan_value),
		.chan_quality(chan_quality), .safety_error(safety_error),
		.slave_confirm_state(confirm), .slave_comm_state(comm),
		.diag_valid(diag_valid), .diag_data(diag_data),
		.diag_ready(diag_ready), .irq(irq));

	diag_sink u_sink (.aclk(aclk), .aresetn(aresetn),
		.diag_valid(diag_valid), .diag_data(diag_data),
		.diag_ready(diag_ready), .got(got), .got_data(got_data));

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task close_out;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Waits until every expected diagnosis byte has been matched
	task drain;
		int n;
		n = 0;
		while (q.size() != 0) begin
			n++;
			if (n > 200) begin
				errors++;
				close_out;
			end
			@(posedge aclk);
		end
	endtask
	// Ends at a falling edge with the awaited signal high
	task wt(input int k);
		int n;
		n = 0;
		@(negedge aclk);
		while (rdy[k] !== 1'b1) begin
			n++;
			if (n > 50) begin
				errors++;
				close_out;
			end
			@(negedge aclk);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		wt(0);
		@(posedge aclk);
		awv <= 1'b0;
		wv <= 1'b0;
		wt(1);
		chk("bresp", e, bresp);
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		wt(2);
		@(posedge aclk);
		arv <= 1'b0;
		wt(3);
		chk("rdata", d, rdata);
		chk("rresp", e, rresp);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Oldest expected diagnosis byte is matched against each byte taken
	always @(posedge aclk) begin
		if (got === 1'b1) begin
			if (q.size() == 0)
				chk("diag_extra", 32'h0, 32'h1);
			else
				chk("diag_data", q.pop_front(), got_data);
		end
	end

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{awv, wv, bready, arv, rready, comm_fail, module_fail} = '0;
		{psafe_fault, aresetn, awaddr, araddr, wdata, acq_fault} = '0;
		chan_in = 8'h03;
		void'($urandom(32'hcb0c73e2));
		cyc(10);
		aresetn <= 1'b1;
		cyc(20);
		@(negedge aclk);
		chk("confirm", 32'h1, confirm);
		chk("comm", 32'h1, comm);
		chk("quality", 32'h0, chan_quality);
		axw(`OFS_CFG, 32'h0000_0001, `RESP_OKAY);
		axr(`OFS_CFG, 32'h0000_0001, `RESP_OKAY);
		axr(8'h40, 32'h0, `RESP_SLVERR);
		axw(8'h44, 32'h1, `RESP_SLVERR);
		$display("test registers done");
		q = {q, 8'h80, 8'h40, 8'h32, 8'h80, 8'h41, 8'h32};
		acq_fault <= 8'h03;
		drain;
		chan_in <= 8'h00;
		cyc(3);
		@(negedge aclk);
		chk("quality", 32'h3, chan_quality);
		chk("value", 32'h2, chan_value);
		axr(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
		@(negedge aclk);
		chk("irq_masked", 32'h0, irq);
		axw(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
		@(negedge aclk);
		chk("irq_mask", 32'h1, irq);
		axw(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
		@(negedge aclk);
		chk("irq", 32'h0, irq);
		$display("test acquisition fault done");
		@(posedge aclk);
		q = {q, 8'h80, 8'h40, 8'h20, 8'h80, 8'h41, 8'h20};
		acq_fault <= 8'h00;
		chan_in <= 8'h03;
		drain;
		cyc(2);
		@(negedge aclk);
		chk("value", 32'h3, chan_value);
		chk("fifo", 32'h0, q.size());
		$display("test recovery done");
		@(posedge aclk);
		r = 8'($urandom);
		chan_in <= r;
		psafe_fault <= 1'b1;
		axw(`OFS_CFG, 32'h0000_a501, `RESP_OKAY);
		@(negedge aclk);
		chk("safety_error", 32'h1, safety_error);
		chk("value", 32'ha5, chan_value);
		chk("quality", 32'hff, chan_quality);
		chk("confirm", 32'h0, confirm);
		@(posedge aclk);
		psafe_fault <= 1'b0;
		cyc(3);
		@(negedge aclk);
		chk("safety_error", 32'h0, safety_error);
		chk("confirm", 32'h1, confirm);
		chk("value", {24'h0, r}, chan_value);
		axr(`OFS_IRQ_STAT, 32'h6, `RESP_OKAY);
		axr(`OFS_CONFIRM, 32'h1, `RESP_OKAY);
		$display("test fault-safe done");
		comm_fail <= 1'b1;
		cyc(3);
		@(negedge aclk);
		chk("value", 32'ha5, chan_value);
		chk("comm_bad", 32'h0, comm == 8'h01);
		axr(`OFS_STATUS, 32'h0000_00ff, `RESP_OKAY);
		comm_fail <= 1'b0;
		module_fail <= 1'b1;
		cyc(3);
		@(negedge aclk);
		chk("value", 32'ha5, chan_value);
		@(posedge aclk);
		module_fail <= 1'b0;
		$display("test comm and module failure done");
		close_out;
	end
endmodule // test_channel_diag_safe_state
